// file: src/spdf_serial_port.sv
// Serial port with DTR hold-off and DSR output gating, device side
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module spdf_serial_port
   import spdf_pkg::*;
#(
   parameter int CLK_HZ     = spdf_pkg::CLK_HZ_DEF,
   parameter int FIFO_DEPTH = spdf_pkg::RX_FIFO_DEPTH
) (
   input  wire logic                 clk_i,
   input  wire logic                 resetn_i,
   input  wire spdf_pkg::spdf_bus_t  bus_i,
   output logic [31:0]               rdata_o,
   input  wire spdf_pkg::spdf_cfg_t  nv_cfg_i,
   output spdf_pkg::spdf_cfg_t       nv_cfg_o,
   output logic                      nv_save_o,
   input  wire logic                 rxd_i,
   output logic                      txd_o,
   output logic                      dtr_o,
   input  wire logic                 dsr_i,
   output logic                      abort_o
);
   import spdf_pkg::*;

   localparam int CNT_W = $clog2(CLK_HZ / SLOWEST_BAUD + 1);

   // Fastest rate still needs a few cycles per bit for mid-bit sampling
   if (CLK_HZ / FASTEST_BAUD < MIN_BIT_CYC || FIFO_DEPTH < 2) begin : g_chk
      $error("spdf_serial_port: clock too slow for 9600 baud or FIFO too small");
   end

   typedef struct packed {
      spdf_cfg_t         cfg;
      logic              save;
      logic              armed;
      logic              talk;
      logic              resp_end;
      spdf_fr_t          tx_st;
      logic [CNT_W-1:0]  tx_cnt;
      logic [2:0]        tx_idx;
      logic [7:0]        tx_sh;
      logic              tx_par;
      logic [7:0]        tx_hold;
      logic              tx_hold_v;
      logic              txd;
      spdf_fr_t          rx_st;
      logic [CNT_W-1:0]  rx_cnt;
      logic [2:0]        rx_idx;
      logic [7:0]        rx_sh;
      logic              rx_par;
      logic              rx_ferr;
      logic              ovr;
      logic              ferr;
      logic              perr;
      logic              abort_seen;
      logic              abort;
      logic              dtr;
      logic [31:0]       rdata;
   } spdf_st_t;

   spdf_st_t          q;
   spdf_st_t          d;
   logic [CNT_W-1:0]  bitc;
   logic              seven;
   logic [2:0]        last_data;
   logic              suspended;
   logic              rx_push;
   logic              rx_ctrlc;
   logic              rx_pop;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic [7:0]        fifo_out_data;
   logic [31:0]       stat;

   // Bit period in clock cycles for each selectable rate
   function automatic logic [CNT_W-1:0] bit_cycles(input logic [2:0] sel);
      int rate;
      case (sel)
         BAUD_300:  rate = 300;
         BAUD_600:  rate = 600;
         BAUD_1200: rate = 1200;
         BAUD_2400: rate = 2400;
         BAUD_4800: rate = 4800;
         default:   rate = 9600;
      endcase
      return CNT_W'(CLK_HZ / rate);
   endfunction

   // Parity over the seven data bits only
   function automatic logic par_bit(input logic [7:0] c, input logic [1:0] p);
      return (p == PAR_ODD) ? ~^c[6:0] : ^c[6:0];
   endfunction

   assign bitc      = bit_cycles(q.cfg.baud);
   assign seven     = q.cfg.parity != PAR_NONE;
   assign last_data = seven ? 3'h6 : 3'h7;
   assign suspended = q.tx_hold_v && q.tx_st == FR_IDLE && !dsr_i;

   assign stat = {20'h0, q.abort_seen, q.perr, q.ferr, q.ovr, 2'h0, suspended, q.talk,
                  q.dtr, q.tx_st != FR_IDLE, q.tx_hold_v, fifo_out_valid};

   // Received characters wait here for software
   spdf_fifo #(
      .W     (CHAR_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (rx_push),
      .in_data_i   (q.rx_sh),
      .in_ready_o  (fifo_in_ready),
      .out_valid_o (fifo_out_valid),
      .out_data_o  (fifo_out_data),
      .out_ready_i (rx_pop)
   );

   // All next-state logic; bus clears come first so hardware sets win
   always_comb begin
      d          = q;
      d.save     = 1'b0;
      d.abort    = 1'b0;
      d.rdata    = 32'h0;
      rx_push    = 1'b0;
      rx_ctrlc   = 1'b0;
      rx_pop     = bus_i.re && bus_i.addr == ADDR_RXDATA && fifo_out_valid;

      // Register writes
      if (bus_i.we) begin
         case (bus_i.addr)
            ADDR_CFG: begin
               // Unknown rate or format codes are ignored, not stored
               if (bus_i.wdata[CFG_BAUD_LSB +: 3] <= BAUD_9600 &&
                   bus_i.wdata[CFG_PAR_LSB +: 2] <= PAR_ODD) begin
                  d.cfg.baud   = bus_i.wdata[CFG_BAUD_LSB +: 3];
                  d.cfg.parity = bus_i.wdata[CFG_PAR_LSB +: 2];
                  d.save       = 1'b1;
               end
            end
            ADDR_CTRL: begin
               d.armed    = q.armed | bus_i.wdata[CTRL_ARM];
               d.resp_end = q.resp_end | (q.talk & bus_i.wdata[CTRL_RESP_END]);
            end
            ADDR_STAT: begin
               d.ovr        = q.ovr & ~bus_i.wdata[ST_OVR];
               d.ferr       = q.ferr & ~bus_i.wdata[ST_FERR];
               d.perr       = q.perr & ~bus_i.wdata[ST_PERR];
               d.abort_seen = q.abort_seen & ~bus_i.wdata[ST_ABORT];
            end
            ADDR_TXDATA: begin
               // A write while the holding slot is full is dropped
               if (!q.tx_hold_v) begin
                  d.tx_hold   = bus_i.wdata[7:0];
                  d.tx_hold_v = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end

      // Register reads, answered in the next cycle; unmapped reads return zero
      if (bus_i.re) begin
         case (bus_i.addr)
            ADDR_CFG:    d.rdata = {26'h0, q.cfg.parity, 1'b0, q.cfg.baud};
            ADDR_CTRL:   d.rdata = {30'h0, q.resp_end, q.armed};
            ADDR_STAT:   d.rdata = stat;
            ADDR_RXDATA: d.rdata = {23'h0, fifo_out_valid, fifo_out_data};
            default:     d.rdata = 32'h0;
         endcase
      end

      // Transmit sequencer; DSR gates only the start of a character
      if (q.tx_st != FR_IDLE) begin
         d.tx_cnt = (q.tx_cnt == '0) ? bitc - 1'b1 : q.tx_cnt - 1'b1;
      end
      case (q.tx_st)
         FR_IDLE: begin
            if (q.tx_hold_v && dsr_i) begin
               d.tx_st     = FR_START;
               d.tx_sh     = seven ? {1'b0, q.tx_hold[6:0]} : q.tx_hold;
               d.tx_par    = par_bit(q.tx_hold, q.cfg.parity);
               d.tx_hold_v = 1'b0;
               d.tx_cnt    = bitc - 1'b1;
            end
         end
         FR_START: begin
            if (q.tx_cnt == '0) begin
               d.tx_st  = FR_DATA;
               d.tx_idx = 3'h0;
            end
         end
         FR_DATA: begin
            if (q.tx_cnt == '0) begin
               d.tx_sh  = {1'b0, q.tx_sh[7:1]};
               d.tx_idx = q.tx_idx + 3'h1;
               if (q.tx_idx == last_data) begin
                  d.tx_st  = seven ? FR_PAR : FR_STOP;
                  d.tx_idx = 3'h0;
               end
            end
         end
         FR_PAR: begin
            if (q.tx_cnt == '0) begin
               d.tx_st  = FR_STOP;
               d.tx_idx = 3'h0;
            end
         end
         FR_STOP: begin
            if (q.tx_cnt == '0) begin
               d.tx_idx = q.tx_idx + 3'h1;
               if (q.tx_idx == 3'(STOP_BITS - 1)) begin
                  d.tx_st  = FR_IDLE;
                  d.tx_idx = 3'h0;
               end
            end
         end
         default: d.tx_st = FR_IDLE;
      endcase

      // Receive sequencer, sampling each bit in its middle
      if (q.rx_st != FR_IDLE) begin
         d.rx_cnt = (q.rx_cnt == '0) ? bitc - 1'b1 : q.rx_cnt - 1'b1;
      end
      case (q.rx_st)
         FR_IDLE: begin
            if (!rxd_i) begin
               d.rx_st   = FR_START;
               d.rx_cnt  = bitc >> 1;
               d.rx_ferr = 1'b0;
            end
         end
         FR_START: begin
            if (q.rx_cnt == '0) begin
               // A start bit gone high by mid-bit was a glitch
               d.rx_st  = rxd_i ? FR_IDLE : FR_DATA;
               d.rx_idx = 3'h0;
            end
         end
         FR_DATA: begin
            if (q.rx_cnt == '0) begin
               d.rx_sh  = {rxd_i, q.rx_sh[7:1]};
               d.rx_idx = q.rx_idx + 3'h1;
               if (q.rx_idx == last_data) begin
                  if (seven) begin
                     d.rx_sh = {1'b0, rxd_i, q.rx_sh[7:2]};
                  end
                  d.rx_st  = seven ? FR_PAR : FR_STOP;
                  d.rx_idx = 3'h0;
               end
            end
         end
         FR_PAR: begin
            if (q.rx_cnt == '0) begin
               d.rx_par = rxd_i;
               d.rx_st  = FR_STOP;
               d.rx_idx = 3'h0;
            end
         end
         FR_STOP: begin
            if (q.rx_cnt == '0) begin
               d.rx_ferr = q.rx_ferr | ~rxd_i;
               d.rx_idx  = q.rx_idx + 3'h1;
               if (q.rx_idx == 3'(STOP_BITS - 1)) begin
                  d.rx_st  = FR_IDLE;
                  d.rx_idx = 3'h0;
                  d.ferr   = d.ferr | d.rx_ferr;
                  if (seven && (par_bit(q.rx_sh, q.cfg.parity) != q.rx_par)) begin
                     d.perr = 1'b1;
                  end
                  if (q.rx_sh == CHAR_CTRLC) begin
                     rx_ctrlc = 1'b1;
                  end else begin
                     rx_push = 1'b1;
                     // Characters past a full buffer are lost and flagged
                     if (!fifo_in_ready) begin
                        d.ovr = 1'b1;
                     end
                     if (q.rx_sh == CHAR_NL && q.armed) begin
                        d.talk  = 1'b1;
                        d.armed = 1'b0;
                     end
                  end
               end
            end
         end
         default: d.rx_st = FR_IDLE;
      endcase

      // Talk phase ends once the marked response has fully left the line
      if (q.talk && q.resp_end && !q.tx_hold_v && q.tx_st == FR_IDLE) begin
         d.talk     = 1'b0;
         d.resp_end = 1'b0;
      end

      // Ctrl-C clears the query state and drops output not yet started;
      // a character already on the line finishes so the host sees no broken frame
      if (rx_ctrlc) begin
         d.tx_hold_v  = 1'b0;
         d.talk       = 1'b0;
         d.armed      = 1'b0;
         d.resp_end   = 1'b0;
         d.abort      = 1'b1;
         d.abort_seen = 1'b1;
      end

      // Hold-off: buffer full, response pending or output suspended
      d.dtr = fifo_in_ready && !q.talk && !suspended;

      // Line level follows the next sequencer state so it stays registered
      case (d.tx_st)
         FR_START: d.txd = 1'b0;
         FR_DATA:  d.txd = d.tx_sh[0];
         FR_PAR:   d.txd = d.tx_par;
         default:  d.txd = 1'b1;
      endcase
   end

   // Settings are reloaded from retained storage, never from a fixed default
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         q       <= '0;
         q.cfg   <= nv_cfg_i;
         q.tx_st <= FR_IDLE;
         q.rx_st <= FR_IDLE;
         q.txd   <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign rdata_o   = q.rdata;
   assign nv_cfg_o  = q.cfg;
   assign nv_save_o = q.save;
   assign txd_o     = q.txd;
   assign dtr_o     = q.dtr;
   assign abort_o   = q.abort;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_leave_data;
      (q.tx_st == FR_DATA) ##1 (q.tx_st != FR_DATA);
   endsequence

   sequence s_char_start;
      (q.tx_st == FR_IDLE) ##1 (q.tx_st == FR_START);
   endsequence

   a_dtr_full : assert property (!fifo_in_ready |=> !dtr_o)
      else $error("DTR high while receive buffer full");
   a_dtr_reopen : assert property ((fifo_in_ready && !q.talk && !suspended) |=> dtr_o)
      else $error("DTR not reasserted with space free");
   a_dtr_talk : assert property (q.talk |=> !dtr_o)
      else $error("DTR high during response");
   a_dtr_susp : assert property (suspended |=> !dtr_o)
      else $error("DTR high while output suspended");
   a_dsr_gate : assert property (s_char_start |-> $past(dsr_i))
      else $error("character started without DSR");
   a_frame_order : assert property (s_leave_data |->
      (q.tx_st == (seven ? FR_PAR : FR_STOP)) && (txd_o == (seven ? q.tx_par : 1'b1)))
      else $error("wrong field after data bits");
   a_start_low : assert property ((q.tx_st == FR_START) |-> !txd_o)
      else $error("start bit not low");
   a_stop_high : assert property ((q.tx_st == FR_STOP) |-> txd_o)
      else $error("stop bit not high");
   a_ctrlc_drop : assert property (rx_ctrlc |=> !q.tx_hold_v && !q.talk && abort_o)
      else $error("Ctrl-C did not discard output");
   a_cfg_keep : assert property (@(posedge clk_i) disable iff (1'b0)
      !resetn_i |=> nv_cfg_o == $past(nv_cfg_i))
      else $error("settings not reloaded at reset");
endmodule

// file: src/spdf_pkg.sv
// Shared constants and types for the serial port with DTR/DSR hold-off
package spdf_pkg;

   // Clock and line figures
   localparam int CLK_HZ_DEF    = 20_000_000;
   localparam int RX_FIFO_DEPTH = 16;
   localparam int CHAR_W        = 8;
   localparam int STOP_BITS     = 2;
   localparam int SLOWEST_BAUD  = 300;
   localparam int FASTEST_BAUD  = 9600;
   localparam int MIN_BIT_CYC   = 4;

   // Rate selector codes
   localparam logic [2:0] BAUD_300  = 3'h0;
   localparam logic [2:0] BAUD_600  = 3'h1;
   localparam logic [2:0] BAUD_1200 = 3'h2;
   localparam logic [2:0] BAUD_2400 = 3'h3;
   localparam logic [2:0] BAUD_4800 = 3'h4;
   localparam logic [2:0] BAUD_9600 = 3'h5;

   // Parity selector codes; parity also fixes the data width
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD  = 2'h2;

   // Special characters
   localparam logic [7:0] CHAR_NL    = 8'h0a;
   localparam logic [7:0] CHAR_CTRLC = 8'h03;

   // Register byte addresses
   localparam logic [7:0] ADDR_CFG    = 8'h00;
   localparam logic [7:0] ADDR_CTRL   = 8'h04;
   localparam logic [7:0] ADDR_STAT   = 8'h08;
   localparam logic [7:0] ADDR_RXDATA = 8'h0c;
   localparam logic [7:0] ADDR_TXDATA = 8'h10;

   // Field positions
   localparam int CFG_BAUD_LSB  = 0;
   localparam int CFG_PAR_LSB   = 4;
   localparam int CTRL_ARM      = 0;
   localparam int CTRL_RESP_END = 1;
   localparam int RXD_VALID     = 8;
   localparam int ST_RX_VALID   = 0;
   localparam int ST_TX_FULL    = 1;
   localparam int ST_TX_BUSY    = 2;
   localparam int ST_DTR        = 3;
   localparam int ST_TALK       = 4;
   localparam int ST_SUSP       = 5;
   localparam int ST_OVR        = 8;
   localparam int ST_FERR       = 9;
   localparam int ST_PERR       = 10;
   localparam int ST_ABORT      = 11;

   // Retained line settings
   typedef struct packed {
      logic [1:0] parity;
      logic [2:0] baud;
   } spdf_cfg_t;

   localparam spdf_cfg_t CFG_FACTORY = '{parity: PAR_NONE, baud: BAUD_9600};

   // Register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        we;
      logic        re;
   } spdf_bus_t;

   // Frame sequencer states, one-hot, shared by both directions
   typedef enum logic [4:0] {
      FR_IDLE  = 5'h01,
      FR_START = 5'h02,
      FR_DATA  = 5'h04,
      FR_PAR   = 5'h08,
      FR_STOP  = 5'h10
   } spdf_fr_t;

endpackage

// file: src/spdf_fifo.sv
// Receive FIFO with valid/ready on both sides
`timescale 1ns/100ps
module spdf_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } spdf_fifo_st_t;

   spdf_fifo_st_t  q;
   spdf_fifo_st_t  d;
   logic [W-1:0]   mem [DEPTH];
   logic           do_wr;
   logic           do_rd;

   // Pointer math needs a power-of-two depth
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("spdf_fifo: DEPTH must be a power of two, at least 2");
   end

   // Extra pointer bit tells full from empty
   assign in_ready_o  = (q.wr[AW] == q.rd[AW]) || (q.wr[AW-1:0] != q.rd[AW-1:0]);
   assign out_valid_o = q.wr != q.rd;
   assign out_data_o  = mem[q.rd[AW-1:0]];
   assign do_wr       = in_valid_i && in_ready_o;
   assign do_rd       = out_valid_o && out_ready_i;

   // Next pointers
   always_comb begin
      d = q;
      if (do_wr) begin
         d.wr = q.wr + 1'b1;
      end
      if (do_rd) begin
         d.rd = q.rd + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Storage is not reset; only words behind the pointers are ever read
   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem[q.wr[AW-1:0]] <= in_data_i;
      end
   end

   a_no_push_full : assert property (@(posedge clk_i) disable iff (!resetn_i)
      (!in_ready_o && !do_rd) |=> !in_ready_o)
      else $error("fifo left full without a pop");
endmodule

// file: tb/spdf_host_model.sv
// Host-side serial partner: frames characters out and decodes frames in
`timescale 1ns/100ps
module spdf_host_model (
   input  wire logic clk_i,
   input  wire logic txd_i,
   input  wire logic dtr_i,
   output logic      rxd_o
);
   int         bit_cyc = 40;
   logic [1:0] par     = 2'h0;
   int         errs    = 0;
   logic [7:0] got[$];

   // Idle line sits high
   initial rxd_o = 1'b1;

   // Frame out; waits for DTR unless told to push through a hold-off
   task automatic send(input logic [7:0] c, input bit force_i);
      logic [11:0] fr;
      int          n;
      int          k;
      fr = 12'hfff;
      fr[0] = 1'b0;
      n = (par == 2'h0) ? 8 : 7;
      for (k = 0; k < n; k++) fr[1 + k] = c[k];
      if (par != 2'h0) fr[8] = ^c[6:0] ^ par[1];
      n = n + ((par != 2'h0) ? 3 : 2);
      for (k = 0; k < 100000 && !force_i && dtr_i !== 1'b1; k++) @(posedge clk_i);
      for (k = 0; k <= n; k++) begin
         @(posedge clk_i);
         rxd_o <= fr[k];
         repeat (bit_cyc - 1) @(posedge clk_i);
      end
   endtask

   // Decoder samples mid-bit and counts framing or parity slips
   always begin
      logic [7:0] d;
      int         nb;
      @(negedge txd_i);
      d = 8'h00;
      nb = (par == 2'h0) ? 8 : 7;
      repeat (bit_cyc / 2) @(posedge clk_i);
      if (txd_i !== 1'b0) errs++;
      for (int i = 0; i < nb; i++) begin
         repeat (bit_cyc) @(posedge clk_i);
         d[i] = txd_i;
      end
      if (par != 2'h0) begin
         repeat (bit_cyc) @(posedge clk_i);
         if (txd_i !== (^d[6:0] ^ par[1])) errs++;
      end
      repeat (2) begin
         repeat (bit_cyc) @(posedge clk_i);
         if (txd_i !== 1'b1) errs++;
      end
      got.push_back(d);
   end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the serial port with DTR/DSR hold-off
`timescale 1ns/100ps
module tb_top;
   import spdf_pkg::*;
   localparam int CLK = 384000;
   logic        clk_i    = 1'b0;
   logic        resetn_i = 1'b0;
   spdf_bus_t   bus_i    = '0;
   spdf_cfg_t   nv_cfg_i = CFG_FACTORY;
   logic        dsr_i    = 1'b1;
   spdf_cfg_t   nv_cfg_o;
   logic [31:0] rdata_o;
   logic        nv_save_o, rxd_i, txd_o, dtr_o, abort_o;
   int          mismatches = 0;
   int          comparisons = 0;
   int          aborts = 0;
   int          saves = 0;
   logic [7:0]  mask = 8'hff;
   logic [7:0]  c;
   logic [31:0] v;
   logic [7:0]  exp_rx[$];
   logic [7:0]  exp_tx[$];
   int          rates[6] = '{300, 600, 1200, 2400, 4800, 9600};

   always #25 clk_i = ~clk_i;

   spdf_serial_port #(.CLK_HZ(CLK), .FIFO_DEPTH(16)) dut_u (
      .clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
      .nv_cfg_i(nv_cfg_i), .nv_cfg_o(nv_cfg_o), .nv_save_o(nv_save_o), .rxd_i(rxd_i),
      .txd_o(txd_o), .dtr_o(dtr_o), .dsr_i(dsr_i), .abort_o(abort_o));

   spdf_host_model host_u (.clk_i(clk_i), .txd_i(txd_o), .dtr_i(dtr_o), .rxd_o(rxd_i));

   // Pulse counters, so one-cycle strobes are never missed
   always @(posedge clk_i) begin
      if (abort_o === 1'b1) aborts++;
      if (nv_save_o === 1'b1) saves++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      bus_i <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk_i);
      bus_i.we <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      bus_i <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
      @(posedge clk_i);
      bus_i.re <= 1'b0;
      #1 d = rdata_o;
   endtask

   task automatic set_cfg(input logic [1:0] p, input logic [2:0] b);
      wr(ADDR_CFG, {26'h0, p, 1'b0, b});
      host_u.par = p;
      host_u.bit_cyc = CLK / rates[b];
      mask = (p == PAR_NONE) ? 8'hff : 8'h7f;
      repeat (2) @(posedge clk_i);
      chk(nv_cfg_o, {p, b});
      rd(ADDR_CFG, v);
      chk(v, {26'h0, p, 1'b0, b});
   endtask

   task automatic pop_chk();
      rd(ADDR_RXDATA, v);
      chk(v, {23'h0, 1'b1, exp_rx.pop_front()});
   endtask

   // Waits for the host to decode one character and checks it against the model
   task automatic tx_wait();
      int k;
      for (k = 0; k < 20000 && host_u.got.size() == 0; k++) @(posedge clk_i);
      c = (host_u.got.size() > 0) ? host_u.got.pop_front() : 8'hxx;
      chk(c, exp_tx.pop_front());
   endtask

   task automatic tx_one(input logic [7:0] d);
      exp_tx.push_back(d & mask);
      wr(ADDR_TXDATA, {24'h0, d});
      tx_wait();
   endtask

   task automatic hsend(input logic [7:0] d, input bit f);
      host_u.send(d, f);
      if (d != CHAR_CTRLC) exp_rx.push_back(d & mask);
   endtask

   task automatic tally_and_finish();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Watchdog sized well past the roughly 40k cycles the tests need
   initial begin
      repeat (90000) @(posedge clk_i);
      mismatches++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      void'($urandom(32'h54e3));
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 chk(nv_cfg_o, CFG_FACTORY);
      chk(dtr_o, 1);
      for (int p = 0; p < 3; p++) begin
         set_cfg(p[1:0], BAUD_9600);
         c = 8'($urandom_range(32, 126));
         if (p == 0) c[7] = 1'b1;
         tx_one(c);
         hsend(c, 1'b0);
         pop_chk();
         chk(host_u.errs, 0);
      end
      $display("formats done");
      for (int b = 0; b < 6; b++) begin
         set_cfg(PAR_NONE, b[2:0]);
         tx_one(8'($urandom_range(32, 255)));
      end
      chk(host_u.errs, 0);
      $display("rates done");
      set_cfg(PAR_NONE, BAUD_9600);
      for (int i = 0; i < 16; i++) hsend(8'($urandom_range(32, 126)), 1'b0);
      #1 chk(dtr_o, 0);
      pop_chk();
      repeat (3) @(posedge clk_i);
      #1 chk(dtr_o, 1);
      repeat (15) pop_chk();
      rd(8'h20, v);
      chk(v, 0);
      $display("buffer done");
      @(posedge clk_i);
      dsr_i <= 1'b0;
      exp_tx.push_back(8'h5a);
      wr(ADDR_TXDATA, 32'h5a);
      repeat (600) @(posedge clk_i);
      #1 chk(host_u.got.size(), 0);
      chk(dtr_o, 0);
      @(posedge clk_i);
      dsr_i <= 1'b1;
      tx_wait();
      $display("dsr done");
      wr(ADDR_CTRL, 32'h1);
      hsend(CHAR_NL, 1'b0);
      #1 chk(dtr_o, 0);
      tx_one(8'h31);
      #1 chk(dtr_o, 0);
      wr(ADDR_CTRL, 32'h2);
      // The last stop bit must leave the line before the talk phase ends
      repeat (host_u.bit_cyc + 4) @(posedge clk_i);
      #1 chk(dtr_o, 1);
      pop_chk();
      $display("query done");
      @(posedge clk_i);
      dsr_i <= 1'b0;
      wr(ADDR_TXDATA, 32'h77);
      repeat (4) @(posedge clk_i);
      hsend(CHAR_CTRLC, 1'b1);
      repeat (20) @(posedge clk_i);
      chk(aborts, 1);
      dsr_i <= 1'b1;
      repeat (600) @(posedge clk_i);
      chk(host_u.got.size(), 0);
      rd(ADDR_STAT, v);
      chk(v[ST_ABORT], 1);
      $display("abort done");
      set_cfg(PAR_EVEN, BAUD_4800);
      resetn_i <= 1'b0;
      nv_cfg_i <= nv_cfg_o;
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 chk(nv_cfg_o, {PAR_EVEN, BAUD_4800});
      chk(dtr_o, 1);
      chk(saves, 11);
      $display("retention done");
      tally_and_finish();
   end
endmodule
